/* rtl/i2c_pot_slave.sv */
// Two-wire slave port and terminal control of the quad pot device
`timescale 1ns/100ps
`include "i2c_link_map.svh"
module i2c_pot_slave
  import i2c_link_pkg::*;
(
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  // Serial link
  i2c_link_if.dev LINK,
  // Address pins
  input wire logic ADDR_PIN_BIT_ZERO,
  input wire logic ADDR_PIN_BIT_ONE,
  // Configuration
  input wire logic GENERAL_CALL_ENABLE,
  // Resistor network control
  output logic [35:0] WIPER_POS,
  output logic [3:0] TERM_A_CONN,
  output logic [3:0] TERM_W_CONN,
  output logic [3:0] TERM_B_CONN,
  output logic [3:0] WIPER_SHORT_B,
  output logic HS_MODE
);
  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers and edge detection
  logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
  logic a0_m, a0_s, a1_m, a1_s;
  logic scl_rise, scl_fall, start_det, stop_det;

  // Even at 3.4 MHz a clock phase spans over 25 cycles, so three flops of lag are harmless
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      {scl_m, scl_s, scl_d} <= 3'h7;
      {sda_m, sda_s, sda_d} <= 3'h7;
      {a0_m, a0_s, a1_m, a1_s} <= 4'h0;
    end else begin
      scl_m <= LINK.scl;
      scl_s <= scl_m;
      scl_d <= scl_s;
      sda_m <= LINK.sda;
      sda_s <= sda_m;
      sda_d <= sda_s;
      a0_m <= ADDR_PIN_BIT_ZERO;
      a0_s <= a0_m;
      a1_m <= ADDR_PIN_BIT_ONE;
      a1_s <= a1_m;
    end
  end

  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;
  // Any data edge with the clock high is a condition, never a data bit
  assign start_det = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_det = scl_s & scl_d & ~sda_d & sda_s;

  ////////////////////////////////////////////////////////////////////////////
  // Address bit zero capture
  logic [1:0] settle, next_settle;
  logic addr_zero, next_addr_zero;

  // The pin doubles as the high-voltage command input, so it is read only once
  always_comb begin
    next_settle = settle;
    next_addr_zero = addr_zero;
    if (settle != 2'h3) begin
      next_settle = settle + 2'h1;
      if (settle == 2'h2) begin
        next_addr_zero = a0_s;
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      settle <= 2'h0;
      addr_zero <= 1'b0;
    end else begin
      settle <= next_settle;
      addr_zero <= next_addr_zero;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame engine and registers
  dev_state_t state, next_state;
  logic [3:0] cnt, next_cnt;
  logic [7:0] shreg, next_shreg, byte_in, tx_byte;
  logic [1:0] idx, next_idx;
  logic ack_now, next_ack, sda_rel, next_rel, is_read, next_read;
  logic gc_mode, next_gc, gc_used, next_gc_used, hs_mode, next_hs;
  logic tx_hi, next_tx_hi, mack_ok, next_mack;
  cmd_t ptr, next_ptr, cmd;
  logic [8:0] wiper [4];
  logic [8:0] next_wiper [4];
  logic [15:0] term, next_term;
  logic [8:0] cur_val;

  function automatic logic [1:0] wsel(input logic [3:0] a);
    return {a[2], a[0]};
  endfunction

  function automatic cmd_t decode_cmd(input logic [7:0] b, input logic gc);
    cmd_t c;
    c = '0;
    if (gc) begin
      c.valid = 1'b1;
      case (b[7:2])
        `GC_WR_W0: c = '{1'b1, `MA_W0, `OP_WR, b[1]};
        `GC_WR_W1: c = '{1'b1, `MA_W1, `OP_WR, b[1]};
        `GC_WR_TC: c = '{1'b1, `MA_TC_LO, `OP_WR, b[1]};
        `GC_INC_W0: c = '{1'b1, `MA_W0, `OP_INC, 1'b0};
        `GC_INC_W1: c = '{1'b1, `MA_W1, `OP_INC, 1'b0};
        `GC_DEC_W0: c = '{1'b1, `MA_W0, `OP_DEC, 1'b0};
        `GC_DEC_W1: c = '{1'b1, `MA_W1, `OP_DEC, 1'b0};
        default: c.valid = 1'b0;
      endcase
    end else begin
      c = '{1'b0, b[7:4], b[3:2], b[0]};
      case (c.addr)
        `MA_W0, `MA_W1, `MA_W2, `MA_W3: c.valid = 1'b1;
        `MA_TC_LO, `MA_TC_HI: c.valid = (c.op == `OP_WR) || (c.op == `OP_RD);
        default: c.valid = 1'b0;
      endcase
    end
    return c;
  endfunction

  assign byte_in = {shreg[6:0], sda_s};
  assign cur_val = (ptr.addr == `MA_TC_LO) ? {1'b1, term[7:0]} :
                   (ptr.addr == `MA_TC_HI) ? {1'b1, term[15:8]} : wiper[wsel(ptr.addr)];
  assign tx_byte = tx_hi ? {7'h00, cur_val[8]} : cur_val[7:0];
  assign cmd = decode_cmd(byte_in, gc_mode);

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_shreg = shreg;
    next_idx = idx;
    next_ack = ack_now;
    next_rel = sda_rel;
    next_read = is_read;
    next_gc = gc_mode;
    next_gc_used = gc_used;
    next_hs = hs_mode;
    next_ptr = ptr;
    next_tx_hi = tx_hi;
    next_mack = mack_ok;
    next_wiper = wiper;
    next_term = term;
    if (stop_det) begin
      next_state = DS_IDLE;
      next_rel = 1'b1;
      next_hs = 1'b0;
    end else if (start_det) begin
      // A repeated start looks the same and also aborts any half-done command
      next_state = DS_RX;
      next_cnt = 4'h0;
      next_idx = 2'h0;
      next_gc = 1'b0;
      next_gc_used = 1'b0;
      next_read = 1'b0;
      next_tx_hi = 1'b1;
      next_rel = 1'b1;
    end else begin
      case (state)
        DS_RX: begin
          if (scl_rise) begin
            next_shreg = byte_in;
            next_cnt = cnt + 4'h1;
            if (cnt == 4'h7) begin
              next_state = DS_ACK_SET;
              next_ack = 1'b0;
              case (idx)
                2'h0: begin
                  next_idx = 2'h1;
                  // Ten-bit prefixes never equal the device code and fall to a nack
                  if (byte_in[7:1] == `GC_ADDR && !byte_in[0]) begin
                    next_ack = GENERAL_CALL_ENABLE;
                    next_gc = 1'b1;
                  end else if (byte_in[7:3] == `HS_CODE) begin
                    next_hs = 1'b1;
                  end else if (byte_in[7:1] == {`DEV_CODE, a1_s, addr_zero}) begin
                    next_ack = 1'b1;
                    next_read = byte_in[0];
                  end
                end
                2'h1: begin
                  // Only one general call command per control byte
                  if (cmd.valid && !gc_used) begin
                    next_ack = 1'b1;
                    next_ptr = cmd;
                    next_gc_used = gc_mode;
                    if (cmd.op == `OP_WR) begin
                      next_idx = 2'h2;
                    end else if (cmd.op == `OP_INC) begin
                      if (wiper[wsel(cmd.addr)] < `WIPER_FULL) begin
                        next_wiper[wsel(cmd.addr)] = wiper[wsel(cmd.addr)] + 9'h001;
                      end
                    end else if (cmd.op == `OP_DEC) begin
                      if (wiper[wsel(cmd.addr)] != 9'h000 &&
                          wiper[wsel(cmd.addr)] <= `WIPER_FULL) begin
                        next_wiper[wsel(cmd.addr)] = wiper[wsel(cmd.addr)] - 9'h001;
                      end
                    end
                  end
                end
                default: begin
                  next_ack = 1'b1;
                  next_idx = 2'h1;
                  // Terminal bits are only stored here; shutdown overrides at the outputs
                  if (ptr.addr == `MA_TC_LO) begin
                    next_term[7:0] = byte_in;
                  end else if (ptr.addr == `MA_TC_HI) begin
                    next_term[15:8] = byte_in;
                  end else begin
                    next_wiper[wsel(ptr.addr)] = {ptr.d8, byte_in};
                  end
                end
              endcase
            end
          end
        end
        DS_ACK_SET: begin
          if (scl_fall) begin
            next_rel = ~ack_now;
            next_state = DS_ACK;
          end
        end
        DS_ACK: begin
          if (scl_fall) begin
            next_cnt = 4'h0;
            if (!ack_now) begin
              next_rel = 1'b1;
              next_state = DS_WAIT;
            end else if (is_read) begin
              // Read data is a register, so it is ready without holding the clock
              next_shreg = tx_byte;
              next_rel = tx_byte[7];
              next_tx_hi = ~tx_hi;
              next_state = DS_TX;
            end else begin
              next_rel = 1'b1;
              next_state = DS_RX;
            end
          end
        end
        DS_TX: begin
          if (scl_rise) begin
            next_cnt = cnt + 4'h1;
          end
          if (scl_fall) begin
            if (cnt == 4'h8) begin
              next_rel = 1'b1;
              next_state = DS_MACK;
            end else begin
              next_rel = shreg[6];
              next_shreg = {shreg[6:0], 1'b0};
            end
          end
        end
        DS_MACK: begin
          if (scl_rise) begin
            next_mack = ~sda_s;
          end
          if (scl_fall) begin
            next_cnt = 4'h0;
            if (mack_ok) begin
              next_shreg = tx_byte;
              next_rel = tx_byte[7];
              next_tx_hi = ~tx_hi;
              next_state = DS_TX;
            end else begin
              next_state = DS_WAIT;
            end
          end
        end
        default: begin
          next_state = state;
        end
      endcase
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      state <= DS_IDLE;
      cnt <= 4'h0;
      shreg <= 8'h00;
      idx <= 2'h0;
      ack_now <= 1'b0;
      sda_rel <= 1'b1;
      is_read <= 1'b0;
      gc_mode <= 1'b0;
      gc_used <= 1'b0;
      hs_mode <= 1'b0;
      ptr <= '0;
      tx_hi <= 1'b1;
      mack_ok <= 1'b0;
      wiper <= '{default: `WIPER_MID};
      term <= `TERM_RST;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      shreg <= next_shreg;
      idx <= next_idx;
      ack_now <= next_ack;
      sda_rel <= next_rel;
      is_read <= next_read;
      gc_mode <= next_gc;
      gc_used <= next_gc_used;
      hs_mode <= next_hs;
      ptr <= next_ptr;
      tx_hi <= next_tx_hi;
      mack_ok <= next_mack;
      wiper <= next_wiper;
      term <= next_term;
    end
  end

  // Open drain: the line is only ever pulled low, and the clock is never touched
  assign LINK.s_sda_o = 1'b0;
  assign LINK.s_sda_oe_n = sda_rel;

  ////////////////////////////////////////////////////////////////////////////
  // Resistor network outputs
  logic [35:0] next_pos;
  logic [3:0] next_a, next_w, next_b, next_short;

  always_comb begin
    next_pos = 36'h0_0000_0000;
    next_a = 4'h0;
    next_w = 4'h0;
    next_b = 4'h0;
    next_short = 4'h0;
    for (int r = 0; r < 4; r++) begin
      next_pos[9*r +: 9] = wiper[r];
      next_short[r] = ~term[4*r+3];
      next_a[r] = term[4*r+3] & term[4*r+2];
      next_w[r] = ~term[4*r+3] | term[4*r+1];
      next_b[r] = ~term[4*r+3] | term[4*r];
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      WIPER_POS <= {4{`WIPER_MID}};
      TERM_A_CONN <= 4'hF;
      TERM_W_CONN <= 4'hF;
      TERM_B_CONN <= 4'hF;
      WIPER_SHORT_B <= 4'h0;
      HS_MODE <= 1'b0;
    end else begin
      WIPER_POS <= next_pos;
      TERM_A_CONN <= next_a;
      TERM_W_CONN <= next_w;
      TERM_B_CONN <= next_b;
      WIPER_SHORT_B <= next_short;
      HS_MODE <= hs_mode;
    end
  end
endmodule // i2c_pot_slave

/* rtl/i2c_link_map.svh */
// Offsets, field positions, reset values and timing counts of the two-wire pot link
// How it works
// - Shutdown force low: A open, wiper to B
// - Shutdown ignores connect bits, keeps their values
// - Shutdown never alters wiper registers
// - Device is slave; master makes clock, start, stop
// - Device samples data on rising clock edge
// - Data changes only while clock low
// - Standard, fast and high-speed clock classes supported
// - Device never stretches the clock
// - Address bit zero caught once after reset
// - Seven-bit addresses only, no ten-bit
// - First byte: device code, address, direction
// - Start is data falling while clock high
// - Ack drives data low in ninth clock
// - Ack own address and enabled general call, nack any other
// - Nack invalid memory address and command pairs
// - Start after an error resets command machine
// - General call acked only when enabled
// - Repeated start handled like a start
// - Stop returns serial interface to idle
// - High-speed code: nack, enter high-speed mode, stop leaves
`ifndef I2C_LINK_MAP_SVH
`define I2C_LINK_MAP_SVH
// Address byte
`define DEV_CODE 5'h0B
`define GC_ADDR 7'h00
`define HS_CODE 5'h01
// Memory address field values
`define MA_W0 4'h0
`define MA_W1 4'h1
`define MA_W2 4'h6
`define MA_W3 4'h7
`define MA_TC_LO 4'h4
`define MA_TC_HI 4'hA
// Command code field values
`define OP_WR 2'h0
`define OP_INC 2'h1
`define OP_DEC 2'h2
`define OP_RD 2'h3
// General call commands, byte bits 7:2
`define GC_WR_W0 6'h20
`define GC_WR_W1 6'h24
`define GC_WR_TC 6'h30
`define GC_INC_W0 6'h21
`define GC_INC_W1 6'h25
`define GC_DEC_W0 6'h22
`define GC_DEC_W1 6'h26
// Wiper full scale, wiper and terminal control reset values
`define WIPER_MID 9'h080
`define WIPER_FULL 9'h100
`define TERM_RST 16'hFFFF
// Controller register offsets and fields
`define OFS_CMD 8'h00
`define OFS_STATUS 8'h04
`define OFS_TXD 8'h08
`define OFS_RXD 8'h0C
`define OFS_DIV 8'h10
`define MOP_START 2'h0
`define MOP_STOP 2'h1
`define MOP_WRITE 2'h2
`define MOP_READ 2'h3
`define CMD_NACK_BIT 2
// Timing: bus rates in kHz and quarter-bit lengths in clock cycles
`define REF_CLK_KHZ 200000
`define SCL_STD_KHZ 100
`define SCL_FAST_KHZ 400
`define SCL_HS_KHZ 3400
`define QTR_CYC_STD ((`REF_CLK_KHZ + 4 * `SCL_STD_KHZ - 1) / (4 * `SCL_STD_KHZ))
`define QTR_CYC_FAST ((`REF_CLK_KHZ + 4 * `SCL_FAST_KHZ - 1) / (4 * `SCL_FAST_KHZ))
`define QTR_CYC_HS ((`REF_CLK_KHZ + 4 * `SCL_HS_KHZ - 1) / (4 * `SCL_HS_KHZ))
`endif

/* rtl/i2c_link_pkg.sv */
// Types shared by the two ends of the pot link
package i2c_link_pkg;
  typedef enum logic [2:0] {
    DS_IDLE = 3'h0, DS_RX = 3'h1, DS_ACK_SET = 3'h3, DS_ACK = 3'h2,
    DS_TX = 3'h6, DS_MACK = 3'h7, DS_WAIT = 3'h5
  } dev_state_t;
  typedef enum logic [1:0] {
    MS_IDLE = 2'h0, MS_START = 2'h1, MS_BYTE = 2'h3, MS_STOP = 2'h2
  } mst_state_t;
  typedef struct packed {
    logic valid;
    logic [3:0] addr;
    logic [1:0] op;
    logic d8;
  } cmd_t;
endpackage

/* rtl/i2c_link_if.sv */
// Open-drain two-wire link joining controller and pot device
`timescale 1ns/100ps
interface i2c_link_if;
  logic scl_o;
  logic scl_oe_n;
  logic m_sda_o;
  logic m_sda_oe_n;
  logic s_sda_o;
  logic s_sda_oe_n;
  logic scl;
  logic sda;
  // Wired-AND with pull-ups: a line is low whenever any enabled driver pulls it
  assign scl = ~(~scl_oe_n & ~scl_o);
  assign sda = ~((~m_sda_oe_n & ~m_sda_o) | (~s_sda_oe_n & ~s_sda_o));
  modport ctrl (output scl_o, scl_oe_n, m_sda_o, m_sda_oe_n, input scl, sda);
  modport dev (output s_sda_o, s_sda_oe_n, input scl, sda);
endinterface

/* rtl/i2c_link_master.sv */
// Two-wire bus controller driven by software over APB
`timescale 1ns/100ps
`include "i2c_link_map.svh"
module i2c_link_master
  import i2c_link_pkg::*;
(
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Serial link
  i2c_link_if.ctrl LINK
);
  logic sda_m, sda_s;
  mst_state_t state, next_state;
  logic [1:0] qtr, next_qtr;
  logic [3:0] bit_i, next_bit;
  logic [15:0] div, next_div, div_cnt, next_div_cnt;
  logic scl_rel, next_scl_rel, sda_rel, next_sda_rel;
  logic [7:0] txd, next_txd, rxd, next_rxd, tx_sh, next_tx_sh, rx_sh, next_rx_sh;
  logic nack_seen, next_nack_seen, is_rd, next_is_rd, send_nack, next_send_nack;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr, wr_acc;

  assign wr_acc = PSEL & PENABLE & PREADY & PWRITE;

  ////////////////////////////////////////////////////////////////////////////
  // Register access and bus sequencer
  always_comb begin
    next_state = state;
    next_qtr = qtr;
    next_bit = bit_i;
    next_div = div;
    next_div_cnt = div_cnt;
    next_scl_rel = scl_rel;
    next_sda_rel = sda_rel;
    next_txd = txd;
    next_rxd = rxd;
    next_tx_sh = tx_sh;
    next_rx_sh = rx_sh;
    next_nack_seen = nack_seen;
    next_is_rd = is_rd;
    next_send_nack = send_nack;
    next_prdata = PRDATA;
    next_pslverr = PSLVERR;
    // One access cycle: ready is raised for the cycle after setup
    next_pready = PSEL & ~PENABLE;
    if (PSEL && !PENABLE) begin
      next_pslverr = 1'b0;
      case (PADDR)
        `OFS_CMD: next_prdata = 32'h0000_0000;
        `OFS_STATUS: next_prdata = {30'h0000_0000, nack_seen, state != MS_IDLE};
        `OFS_TXD: next_prdata = {24'h00_0000, txd};
        `OFS_RXD: next_prdata = {24'h00_0000, rxd};
        `OFS_DIV: next_prdata = {16'h0000, div};
        default: begin
          next_prdata = 32'h0000_0000;
          next_pslverr = 1'b1;
        end
      endcase
    end
    if (wr_acc && PADDR == `OFS_TXD) begin
      next_txd = PWDATA[7:0];
    end
    if (wr_acc && PADDR == `OFS_DIV) begin
      next_div = PWDATA[15:0];
    end
    // Orders given while busy are dropped, software polls the busy bit first
    if (wr_acc && PADDR == `OFS_CMD && state == MS_IDLE) begin
      next_qtr = 2'h0;
      next_bit = 4'h0;
      next_div_cnt = div;
      next_tx_sh = txd;
      next_is_rd = PWDATA[1:0] == `MOP_READ;
      next_send_nack = PWDATA[`CMD_NACK_BIT];
      case (PWDATA[1:0])
        `MOP_START: next_state = MS_START;
        `MOP_STOP: next_state = MS_STOP;
        default: next_state = MS_BYTE;
      endcase
    end else if (state != MS_IDLE) begin
      if (div_cnt != 16'h0000) begin
        next_div_cnt = div_cnt - 16'h0001;
      end else begin
        next_div_cnt = div;
        next_qtr = qtr + 2'h1;
        case (state)
          MS_START: begin
            // From idle or after an ack; a start on a held bus is a repeated start
            case (qtr)
              2'h0: next_sda_rel = 1'b1;
              2'h1: next_scl_rel = 1'b1;
              2'h2: next_sda_rel = 1'b0;
              default: begin
                next_scl_rel = 1'b0;
                next_state = MS_IDLE;
              end
            endcase
          end
          MS_STOP: begin
            case (qtr)
              2'h0: next_sda_rel = 1'b0;
              2'h1: next_scl_rel = 1'b1;
              2'h2: next_sda_rel = 1'b1;
              default: next_state = MS_IDLE;
            endcase
          end
          default: begin
            case (qtr)
              2'h0: begin
                // Data only moves in the low quarter of the clock
                if (bit_i == 4'h8) begin
                  next_sda_rel = is_rd ? send_nack : 1'b1;
                end else begin
                  next_sda_rel = is_rd ? 1'b1 : tx_sh[7];
                end
              end
              2'h1: next_scl_rel = 1'b1;
              2'h2: begin
                if (bit_i == 4'h8) begin
                  next_nack_seen = is_rd ? nack_seen : sda_s;
                end else begin
                  next_rx_sh = {rx_sh[6:0], sda_s};
                end
              end
              default: begin
                next_scl_rel = 1'b0;
                next_tx_sh = {tx_sh[6:0], 1'b0};
                next_bit = bit_i + 4'h1;
                if (bit_i == 4'h8) begin
                  next_state = MS_IDLE;
                  next_rxd = is_rd ? rx_sh : rxd;
                end
              end
            endcase
          end
        endcase
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      state <= MS_IDLE;
      qtr <= 2'h0;
      bit_i <= 4'h0;
      div <= 16'(`QTR_CYC_FAST - 1);
      div_cnt <= 16'h0000;
      scl_rel <= 1'b1;
      sda_rel <= 1'b1;
      txd <= 8'h00;
      rxd <= 8'h00;
      tx_sh <= 8'h00;
      rx_sh <= 8'h00;
      nack_seen <= 1'b0;
      is_rd <= 1'b0;
      send_nack <= 1'b0;
      PRDATA <= 32'h0000_0000;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end else begin
      sda_m <= LINK.sda;
      sda_s <= sda_m;
      state <= next_state;
      qtr <= next_qtr;
      bit_i <= next_bit;
      div <= next_div;
      div_cnt <= next_div_cnt;
      scl_rel <= next_scl_rel;
      sda_rel <= next_sda_rel;
      txd <= next_txd;
      rxd <= next_rxd;
      tx_sh <= next_tx_sh;
      rx_sh <= next_rx_sh;
      nack_seen <= next_nack_seen;
      is_rd <= next_is_rd;
      send_nack <= next_send_nack;
      PRDATA <= next_prdata;
      PREADY <= next_pready;
      PSLVERR <= next_pslverr;
    end
  end

  assign LINK.scl_o = 1'b0;
  assign LINK.scl_oe_n = scl_rel;
  assign LINK.m_sda_o = 1'b0;
  assign LINK.m_sda_oe_n = sda_rel;
endmodule // i2c_link_master

/* sim/i2c_link_sva.sv */
// Assertions on the shared two-wire link between controller and pot device
`timescale 1ns/100ps
module i2c_link_sva (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  // Link signals
  input wire logic scl_o,
  input wire logic scl_oe_n,
  input wire logic m_sda_oe_n,
  input wire logic s_sda_o,
  input wire logic s_sda_oe_n,
  input wire logic scl,
  input wire logic sda
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);
  ////////////////////////////////////////////////////////////////////////////////
  sequence start_s;
    $past(scl) && scl && $fell(sda);
  endsequence
  sequence stop_s;
    $past(scl) && scl && $rose(sda);
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  chk_open_drain: assert property (!scl_o && !s_sda_o)
    else $error("a link driver would drive a line high");
  chk_rst_release: assert property ($fell(SYS_RST) |-> scl_oe_n && m_sda_oe_n && s_sda_oe_n)
    else $error("line pulled right after reset");
  chk_no_stretch: assert property (scl == scl_oe_n)
    else $error("clock low without controller pulling it");
  chk_start_free: assert property (start_s |-> s_sda_oe_n [*8])
    else $error("device drives data around a start");
  chk_stop_idle: assert property (stop_s |=> s_sda_oe_n [*8])
    else $error("device drives data after a stop");
  chk_dev_stable: assert property (scl && $past(scl) |-> $stable(s_sda_oe_n))
    else $error("device changed data while clock high");
  chk_ack_after_fall: assert property ($fell(s_sda_oe_n) |-> !scl && !$past(scl) && !$past(scl, 2))
    else $error("device drove data too soon after clock fall");
  chk_ack_held: assert property ($fell(scl) && !s_sda_oe_n |-> !s_sda_oe_n [*2])
    else $error("device released data at the clock fall");
endmodule // i2c_link_sva

/* sim/test_i2c_slave_terminal_control.sv */
// Bench joining the link controller and the pot device
`timescale 1ns/100ps
`include "i2c_link_map.svh"
module test_i2c_slave_terminal_control;
  import i2c_link_pkg::*;
  logic REF_CLK = 0, SYS_RST = 1, psel = 0, pen = 0, pwr = 0, a0 = 1, a1 = 0, gce = 0;
  logic [7:0] pa = '0;
  logic [31:0] pwd = '0, prd, rd;
  logic prdy, perr, hs, lst;
  logic [35:0] wp;
  logic [3:0] ta, tw, tb, sb;
  int fail_count = 0, checked = 0;
  // Rows: command byte, data byte, wiper expected; pot is row index / 2
  logic [7:0] rc[8] = '{8'h01, 8'h04, 8'h10, 8'h18, 8'h60, 8'h64, 8'h70, 8'h78};
  logic [7:0] rdt[8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h01, 8'h00};
  logic [8:0] rw[8] = '{9'h100, 9'h100, 9'h000, 9'h000, 9'h0FF, 9'h100, 9'h001, 9'h000};
  i2c_link_if i2c_link_if_i ();
  i2c_pot_slave i2c_pot_slave_i (.REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .LINK(i2c_link_if_i),
    .ADDR_PIN_BIT_ZERO(a0), .ADDR_PIN_BIT_ONE(a1), .GENERAL_CALL_ENABLE(gce), .WIPER_POS(wp),
    .TERM_A_CONN(ta), .TERM_W_CONN(tw), .TERM_B_CONN(tb), .WIPER_SHORT_B(sb), .HS_MODE(hs));
  i2c_link_master i2c_link_master_i (.REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .PSEL(psel),
    .PENABLE(pen), .PWRITE(pwr), .PADDR(pa), .PWDATA(pwd), .PRDATA(prd), .PREADY(prdy),
    .PSLVERR(perr), .LINK(i2c_link_if_i));
  i2c_link_sva i2c_link_sva_i (.REF_CLK(REF_CLK), .SYS_RST(SYS_RST),
    .scl_o(i2c_link_if_i.scl_o), .scl_oe_n(i2c_link_if_i.scl_oe_n),
    .m_sda_oe_n(i2c_link_if_i.m_sda_oe_n), .s_sda_o(i2c_link_if_i.s_sda_o),
    .s_sda_oe_n(i2c_link_if_i.s_sda_oe_n), .scl(i2c_link_if_i.scl), .sda(i2c_link_if_i.sda));
  always #2.5 REF_CLK = ~REF_CLK;
  ////////////////////////////////////////////////////////////////////////////////
  task chk(input logic [35:0] s, input logic [35:0] e);
    checked++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, s, e);
    end
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Leading edge wait keeps psel from being assigned twice in one step
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge REF_CLK);
    psel <= 1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge REF_CLK);
    pen <= 1;
    @(posedge REF_CLK);
    // No local limit: only the watchdog may end a wait
    while (prdy !== 1'b1) begin
      @(posedge REF_CLK);
    end
    rd = prd;
    psel <= 0;
    pen <= 0;
  endtask
  task op(input logic [2:0] c, input logic [7:0] b = 8'h00);
    if (c == `MOP_WRITE) apb(1, `OFS_TXD, {24'h00_0000, b});
    apb(1, `OFS_CMD, {29'h0, c});
    rd = '1;
    while (rd[0] !== 1'b0) begin
      apb(0, `OFS_STATUS, '0);
    end
  endtask
  task fr(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2, input int nb);
    op(`MOP_START);
    op(`MOP_WRITE, b0);
    if (nb > 1) op(`MOP_WRITE, b1);
    if (nb > 2) op(`MOP_WRITE, b2);
    lst = rd[1];
    op(`MOP_STOP);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // About 20 frames of under 1000 cycles each; 50000 cycles leaves a wide margin
  initial begin
    #250_000;
    fail_count++;
    finish_test;
  end
  initial begin
    repeat (12) @(posedge REF_CLK);
    SYS_RST <= 0;
    repeat (20) @(posedge REF_CLK);
    a0 <= 0;
    apb(1, `OFS_DIV, 32'h0000_0004);
    for (int i = 0; i < 8; i++) begin
      fr(8'h5A, rc[i], rdt[i], rc[i][3:2] == `OP_WR ? 3 : 2);
      chk(lst, 0);
      chk(wp[9 * (i / 2) +: 9], rw[i]);
    end
    fr(8'h5E, 0, 0, 1);
    chk(lst, 1);
    fr(8'hF0, 0, 0, 1);
    chk(lst, 1);
    fr(8'h00, 0, 0, 1);
    chk(lst, 1);
    gce <= 1;
    fr(8'h00, 8'h80, 8'h33, 3);
    chk({lst, wp[8:0]}, {1'b0, 9'h033});
    fr(8'h5A, 8'h44, 0, 2);
    chk(lst, 1);
    fr(8'h5A, 8'h40, 8'hF6, 3);
    chk({ta[1:0], tw[0], tb[0], sb[0]}, 5'b10111);
    chk(wp[8:0], 9'h033);
    fr(8'h5A, 8'h41, 8'hFE, 3);
    chk({ta[0], tw[0], tb[0], sb[0], wp[8:0]}, {4'b1100, 9'h033});
    op(`MOP_START);
    op(`MOP_WRITE, 8'h08);
    chk({rd[1], hs}, 2'b11);
    op(`MOP_START);
    op(`MOP_WRITE, 8'h5A);
    chk(rd[1], 0);
    op(`MOP_STOP);
    chk(hs, 0);
    fr(8'h5A, 8'h6C, 0, 2);
    op(`MOP_START);
    op(`MOP_WRITE, 8'h5B);
    chk(rd[1], 0);
    op({1'b0, `MOP_READ});
    apb(0, `OFS_RXD, '0);
    chk(rd[7:0], 8'h01);
    op({1'b1, `MOP_READ});
    apb(0, `OFS_RXD, '0);
    chk(rd[7:0], 8'h00);
    op(`MOP_STOP);
    apb(0, 8'h20, '0);
    chk(perr, 1);
    // Mid-run reset must restore the wipers and terminals the frames changed
    SYS_RST <= 1;
    repeat (2) @(posedge REF_CLK);
    SYS_RST <= 0;
    @(posedge REF_CLK);
    chk(wp, {4{`WIPER_MID}});
    chk({ta, tw, tb, sb, hs}, {12'hFFF, 5'h00});
    finish_test;
  end
endmodule // test_i2c_slave_terminal_control
